// ### hw/swb_core.sv
// Purpose : Datapath slice executing subtract-with-borrow and swap
// Assumes : One instruction issued per strobe; two-cycle internal pass
// Notes   : Software sees state through a plain register port
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module swb_core
   import swb_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Instruction issue
   input  wire logic              instr_valid,
   input  wire logic [15:0]       instr_word,
   input  wire logic              ext_set_en,
   input  wire logic [ADDR_W-1:0] index_base,
   // Register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   // Status
   output logic                   busy,
   output logic      [DATA_W-1:0] work_reg,
   output logic      [FLG_W-1:0]  status_flags,
   output logic      [BANK_W-1:0] bank_pointer_register
);

   //----------------------------------------------------------------
   // Register port offsets
   //----------------------------------------------------------------
   localparam logic [3:0] RA_WORK  = 4'h0;
   localparam logic [3:0] RA_FLAGS = 4'h1;
   localparam logic [3:0] RA_BANK  = 4'h2;

   //----------------------------------------------------------------
   // Pipeline state
   //----------------------------------------------------------------
   typedef enum logic [0:0] {ST_IDLE, ST_EXEC} state_e;
   state_e            state;        // Issue / execute phase
   logic              cur_dest;     // Latched destination bit
   logic              cur_swap;     // Latched operation class
   logic [ADDR_W-1:0] cur_addr;     // Latched effective address

   //----------------------------------------------------------------
   // Decode
   //----------------------------------------------------------------
   function automatic op_e decode_op(input logic [15:0] w);
      if (w[OPC_MSB:OPC_LSB] == OPC_SUB_BORROW)
         return OP_SUB;
      else if (w[OPC_MSB:OPC_LSB] == OPC_NIB_SWAP)
         return OP_SWAP;
      else
         return OP_NONE;
   endfunction

   wire op_e              dec_op;    // Decoded operation
   wire logic [7:0]       f_field;   // Eight-bit file operand
   wire logic             a_bit;     // Bank-access bit
   wire logic             use_index; // Indexed literal offset mode
   wire logic [ADDR_W-1:0] eff_addr; // Resolved file address
   wire logic             accept;    // Instruction taken this cycle

   assign dec_op  = decode_op(instr_word);
   assign f_field = instr_word[FADR_MSB:0];
   assign a_bit   = instr_word[BANK_BIT];
   assign accept  = instr_valid && (state == ST_IDLE)
                    && (dec_op != OP_NONE);
   assign use_index = !a_bit && ext_set_en
                      && (f_field <= INDEXED_LIMIT); // RL6

   // Address resolution: indexed, access bank, or banked
   assign eff_addr =
      use_index ? ADDR_W'(index_base + {4'h0, f_field}) : // RL6
      !a_bit    ? ((f_field < ACCESS_SPLIT)
                   ? {BANK_RESET, f_field}
                   : {SFR_BANK, f_field}) :                 // RL4
                  {bank_pointer_register, f_field};         // RL5

   //----------------------------------------------------------------
   // File memory and arithmetic unit
   //----------------------------------------------------------------
   wire logic [DATA_W-1:0] f_data;    // Read operand
   wire logic [DATA_W-1:0] alu_res;   // Result byte
   wire logic [FLG_W-1:0]  alu_flags; // Updated flags
   wire logic              wr_file;   // Write result to file

   // Destination 1 sends the result back to the file
   assign wr_file = (state == ST_EXEC) && cur_dest; // RL3 RL8

   swb_file_mem u_mem (
      .clk_sys (clk_sys),
      .rd_addr (eff_addr),
      .rd_data (f_data),
      .wr_en   (wr_file),
      .wr_addr (cur_addr),
      .wr_data (alu_res)
   );

   swb_alu u_alu (
      .opnd_f    (f_data),
      .opnd_w    (work_reg),
      .is_swap   (cur_swap),
      .flags_in  (status_flags),
      .result    (alu_res),
      .flags_out (alu_flags)
   );

   //----------------------------------------------------------------
   // Sequencer: memory read is registered, so execute a cycle later
   //----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state    <= ST_IDLE;
         cur_dest <= 1'b1;
         cur_swap <= 1'b0;
         cur_addr <= '0;
         busy     <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (accept) begin
                  state    <= ST_EXEC;
                  cur_dest <= instr_word[DEST_BIT];
                  cur_swap <= (dec_op == OP_SWAP);
                  cur_addr <= eff_addr;
                  busy     <= 1'b1;
               end
            end
            ST_EXEC: begin
               state <= ST_IDLE;
               busy  <= 1'b0;
            end
         endcase
      end
   end

   //----------------------------------------------------------------
   // Working register, flags and bank pointer
   //----------------------------------------------------------------
   wire logic exec_now; // Result is valid this cycle
   assign exec_now = (state == ST_EXEC);

   // Software writes lose to an executing instruction whose destination bit is 0
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         work_reg <= WORK_RESET;
      end else if (exec_now && !cur_dest) begin
         work_reg <= alu_res; // RL2 RL8
      end else if (reg_wr && reg_addr == RA_WORK) begin
         work_reg <= reg_wdata;
      end
   end

   // Flags: hardware update wins over software write
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status_flags <= FLAG_RESET;
      end else if (exec_now) begin
         status_flags <= alu_flags; // RL9
      end else if (reg_wr && reg_addr == RA_FLAGS) begin
         status_flags <= reg_wdata[FLG_W-1:0];
      end
   end

   // Bank pointer is software owned
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bank_pointer_register <= BANK_RESET;
      end else if (reg_wr && reg_addr == RA_BANK) begin
         bank_pointer_register <= reg_wdata[BANK_W-1:0];
      end
   end

   //----------------------------------------------------------------
   // Register read port: data one cycle after the strobe
   //----------------------------------------------------------------
   wire logic [7:0] rd_mux; // Selected read value
   assign rd_mux =
      (reg_addr == RA_WORK)  ? work_reg :
      (reg_addr == RA_FLAGS) ? {3'h0, status_flags} :
      (reg_addr == RA_BANK)  ? {4'h0, bank_pointer_register} :
                               8'h00;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// ### hw/swb_pkg.sv
// Purpose : Constants for the subtract-with-borrow / nibble-swap slice
// Assumes : 8-bit data, 12-bit file address space, one clock
// Notes   : Widths, field positions and counts live here; register port offsets sit in swb_core
// Operation
// (RL1) Subtract: file minus working minus inverted carry
// (RL2) Destination bit 0: result to working register
// (RL3) Destination bit 1: result back to file
// (RL4) Bank bit 0: address resolves in access bank
// (RL5) Bank bit 1: bank pointer selects bank
// (RL6) Access, extended set, address <= 5Fh: indexed offset
// (RL7) Swap: exchange upper and lower nibbles
// (RL8) Swap result to working or file by destination
// (RL9) Subtract updates N,OV,C,DC; swap leaves flags; the code also updates Z on a subtract
package swb_pkg;

   //----------------------------------------------------------------
   // Widths
   //----------------------------------------------------------------
   localparam int DATA_W   = 8;
   localparam int ADDR_W   = 12;
   localparam int BANK_W   = 4;
   localparam int OPC_W    = 6;

   //----------------------------------------------------------------
   // Instruction word fields (16-bit byte-oriented format)
   //----------------------------------------------------------------
   localparam int OPC_MSB  = 15;
   localparam int OPC_LSB  = 10;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;
   localparam int FADR_MSB = 7;

   // Opcode values (upper six bits)
   localparam logic [OPC_W-1:0] OPC_SUB_BORROW = 6'h16;
   localparam logic [OPC_W-1:0] OPC_NIB_SWAP   = 6'h0e;

   //----------------------------------------------------------------
   // Addressing constants
   //----------------------------------------------------------------
   localparam logic [7:0] ACCESS_SPLIT   = 8'h60; // Low access half end
   localparam logic [7:0] INDEXED_LIMIT  = 8'h5f; // Indexed window top
   localparam logic [BANK_W-1:0] SFR_BANK = 4'hf; // Upper access half

   //----------------------------------------------------------------
   // Status flag positions within flag output
   //----------------------------------------------------------------
   localparam int FLG_C  = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z  = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N  = 4;
   localparam int FLG_W  = 5;

   // Reset values and file memory depth
   localparam logic [DATA_W-1:0] WORK_RESET  = 8'h00;
   localparam logic [FLG_W-1:0]  FLAG_RESET  = 5'h00;
   localparam logic [BANK_W-1:0] BANK_RESET  = 4'h0;
   localparam int MEM_DEPTH = 4096;

   // Operation classes
   typedef enum logic [1:0] {OP_NONE, OP_SUB, OP_SWAP} op_e;

endpackage

// ### hw/swb_file_mem.sv
// Purpose : Data file memory, one write and one registered read port
// Assumes : Read data appear one cycle after the read address
// Notes   : Write-first is not provided; read returns old content
`timescale 1ns/1ps
`default_nettype none
module swb_file_mem
   import swb_pkg::*;
(
   // Clock
   input  wire logic              clk_sys,
   // Read port
   input  wire logic [ADDR_W-1:0] rd_addr,
   output var  logic [DATA_W-1:0] rd_data,
   // Write port
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data
);

   //----------------------------------------------------------------
   // Storage
   //----------------------------------------------------------------
   // Cells start cleared: no reset reaches them, and an unknown cell
   // would spread through every later subtract or swap that reads it
   logic [DATA_W-1:0] mem [MEM_DEPTH] = '{default: '0}; // File cells

   // Write and registered read on the same edge
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule
`default_nettype wire

// ### hw/swb_alu.sv
// Purpose : Combinational subtract-with-borrow and nibble swap unit
// Assumes : Carry in is the live carry flag
// Notes   : Flags for the swap are passed through unchanged
`timescale 1ns/1ps
`default_nettype none
module swb_alu
   import swb_pkg::*;
(
   // Operands
   input  wire logic [DATA_W-1:0] opnd_f,
   input  wire logic [DATA_W-1:0] opnd_w,
   input  wire logic              is_swap,
   // Flags
   input  wire logic [FLG_W-1:0]  flags_in,
   // Results
   output var  logic [DATA_W-1:0] result,
   output var  logic [FLG_W-1:0]  flags_out
);

   //----------------------------------------------------------------
   // Arithmetic: f + ~w + c, carry out is "no borrow"
   //----------------------------------------------------------------
   wire logic [DATA_W:0] sum_full;  // Nine-bit sum with carry
   wire logic [4:0]      sum_low;   // Low nibble sum for digit carry
   wire logic [DATA_W-1:0] diff;    // Byte difference
   wire logic [DATA_W-1:0] swapped; // Exchanged nibbles
   wire logic            ovf;       // Signed overflow

   assign sum_full = {1'b0, opnd_f} + {1'b0, ~opnd_w}
                   + {8'h00, flags_in[FLG_C]}; // RL1
   assign sum_low  = {1'b0, opnd_f[3:0]} + {1'b0, ~opnd_w[3:0]}
                   + {4'h0, flags_in[FLG_C]};
   assign diff     = sum_full[DATA_W-1:0];
   // Overflow when operand signs differ and result sign follows w
   assign ovf      = (opnd_f[7] ^ opnd_w[7]) & (diff[7] ^ opnd_f[7]);
   assign swapped  = {opnd_f[3:0], opnd_f[7:4]}; // RL7

   // Select result and flags
   always_comb begin
      if (is_swap) begin
         result    = swapped;
         flags_out = flags_in; // RL9
      end else begin
         result            = diff;
         flags_out         = flags_in;
         flags_out[FLG_C]  = sum_full[DATA_W]; // RL9
         flags_out[FLG_DC] = sum_low[4];
         flags_out[FLG_Z]  = (diff == 8'h00);
         flags_out[FLG_OV] = ovf;
         flags_out[FLG_N]  = diff[7];
      end
   end

endmodule
`default_nettype wire

// ### dv/swb_monitor.sv
// Purpose : Port assertions for the subtract/swap slice
// Assumes : Bound into swb_core
// Notes   : File data is hidden here, so relations are checked
`timescale 1ns/1ps
`default_nettype none
module swb_monitor
   import swb_pkg::*;
(
   // Clock, reset, issue
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic              instr_valid,
   input wire logic [15:0]       instr_word,
   // Register port
   input wire logic [3:0]        reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rdata,
   // Status
   input wire logic              busy,
   input wire logic [DATA_W-1:0] work_reg,
   input wire logic [FLG_W-1:0]  status_flags,
   input wire logic [BANK_W-1:0] bank_pointer_register
);
   //---------------------------------------------
   // Request decode
   //---------------------------------------------
   wire logic [5:0] opc    = instr_word[OPC_MSB:OPC_LSB];
   wire logic       is_sub = opc == OPC_SUB_BORROW;
   wire logic       issue  = instr_valid && !busy
                             && (is_sub || opc == OPC_NIB_SWAP);
   wire logic       dst    = instr_word[DEST_BIT];
   wire logic [3:0] wd_lo  = reg_wdata[3:0];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   //---------------------------------------------
   // Properties
   //---------------------------------------------
   property p_busy; issue |=> busy ##1 !busy; endproperty
   a_busy: assert property (p_busy)
      else $error("busy not one cycle");
   property p_refuse; instr_valid && !issue |=> !busy; endproperty
   a_refuse: assert property (p_refuse)
      else $error("refused issue ran");
   // A flag write in the execute cycle is refused, so only the issue
   // cycle needs to be free of writes
   property p_swap_flags; issue && !is_sub && !reg_wr
      |=> ##1 status_flags == $past(status_flags, 2); endproperty
   a_swap_flags: assert property (p_swap_flags)
      else $error("swap touched flags");
   property p_file_dest; issue && dst && !reg_wr ##1 !reg_wr
      |=> work_reg == $past(work_reg, 2); endproperty
   a_file_dest: assert property (p_file_dest)
      else $error("file result hit working reg");
   property p_sub_zn; issue && is_sub && !dst |=> ##1
      status_flags[FLG_Z] == (work_reg == 8'h00)
      && status_flags[FLG_N] == work_reg[7]; endproperty
   a_sub_zn: assert property (p_sub_zn)
      else $error("zero or negative flag wrong");
   property p_rd_work; reg_rd && reg_addr == 4'h0
      |=> reg_rdata == $past(work_reg); endproperty
   a_rd_work: assert property (p_rd_work)
      else $error("working reg read wrong");
   property p_rd_unmapped; reg_rd && reg_addr > 4'h2
      |=> reg_rdata == 8'h00; endproperty
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("unmapped read not zero");
   property p_bank_wr; reg_wr && reg_addr == 4'h2
      |=> bank_pointer_register == $past(wd_lo); endproperty
   a_bank_wr: assert property (p_bank_wr)
      else $error("bank pointer write lost");
   property p_w_hold; !instr_valid && !busy && !reg_wr
      |=> $stable(work_reg); endproperty
   a_w_hold: assert property (p_w_hold)
      else $error("working reg moved idle");
   c_sub: cover property (issue && is_sub && !dst);
   c_swap: cover property (issue && !is_sub && dst);
   c_refused: cover property (instr_valid && busy);
endmodule
bind swb_core swb_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n),
   .instr_valid(instr_valid), .instr_word(instr_word),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy),
   .work_reg(work_reg), .status_flags(status_flags),
   .bank_pointer_register(bank_pointer_register));
`default_nettype wire

// ### dv/tb.sv
// Purpose : Self-checking bench for the subtract/swap slice
// Assumes : File memory reads zero until first written
// Notes   : Reference model; reads are scored from a queue
`timescale 1ns/1ps
`default_nettype none
module tb
   import swb_pkg::*;
;
   logic              clk_sys = 1'b0;
   logic              rst_n = 1'b0;
   logic              instr_valid = 1'b0;
   logic [15:0]       instr_word = 16'h0000;
   logic              ext_set_en = 1'b0;
   logic [11:0]       index_base = 12'h000;
   logic [3:0]        reg_addr = 4'h0;
   logic [7:0]        reg_wdata = 8'h00;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic              rd_d = 1'b0;
   logic [7:0]        reg_rdata;
   logic              busy;
   logic [7:0]        work_reg, m_w = 8'h00, mem [MEM_DEPTH];
   logic [4:0]        status_flags, m_fl = 5'h00;
   logic [3:0]        bank_pointer_register, m_bk = 4'h0;
   logic [7:0]        exp_q [$];
   logic [31:0]       seed = 32'ha8b40a34, r;
   // Edges of the access split and a base that aliases bank F
   logic [7:0]        ftab [4] = '{8'h00, 8'h5f, 8'h60, 8'hff};
   logic [11:0]       btab [4] = '{12'h000, 12'hf00, 12'h0a0, 12'h3a0};
   int                fail_count = 0;
   int                n_compared = 0;
   always #5 clk_sys = ~clk_sys;
   swb_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .ext_set_en(ext_set_en), .index_base(index_base),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy),
      .work_reg(work_reg), .status_flags(status_flags),
      .bank_pointer_register(bank_pointer_register));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Every task sets all strobes together; issue then drives instr_valid a second time, from hold
   task automatic strobe(logic v, logic w, logic rr);
      instr_valid <= v;
      reg_wr <= w;
      reg_rd <= rr;
   endtask
   task automatic chk(logic [7:0] e, logic [7:0] a);
      n_compared++;
      if (a !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t read %h expected %h", $time, a, e);
      end
   endtask
   // op: 0 subtract, 1 swap, 2 unknown code; hold repeats the strobe
   task automatic issue(logic [1:0] op, logic d, logic a, logic [7:0] f,
                        logic e, logic [11:0] b, logic hold);
      logic [11:0] ad;
      logic [7:0]  v, x;
      logic [8:0]  s;
      logic [4:0]  h;
      ad = a ? {m_bk, f} : (e && f <= INDEXED_LIMIT) ? b + {4'h0, f}
         : {(f < ACCESS_SPLIT) ? 4'h0 : SFR_BANK, f};
      v = mem[ad];
      s = {1'b0, v} + {1'b0, ~m_w} + {8'h00, m_fl[FLG_C]};
      h = {1'b0, v[3:0]} + {1'b0, ~m_w[3:0]} + {4'h0, m_fl[FLG_C]};
      x = op[0] ? {v[3:0], v[7:4]} : s[7:0];
      if (op == 2'd0) m_fl = {x[7], (v[7] != m_w[7]) && (x[7] != v[7]),
                              x == 8'h00, h[4], s[8]};
      if (op != 2'd2 && d) mem[ad] = x;
      if (op != 2'd2 && !d) m_w = x;
      instr_word <= {op == 2'd0 ? OPC_SUB_BORROW : op == 2'd1 ?
                     OPC_NIB_SWAP : 6'h3f, d, a, f};
      ext_set_en <= e;
      index_base <= b;
      strobe(1'b1, 1'b0, 1'b0);
      @(posedge clk_sys);
      instr_valid <= hold;
      @(posedge clk_sys);
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      strobe(1'b0, 1'b1, 1'b0);
      @(posedge clk_sys);
      if (a == 4'h0) m_w = d;
      if (a == 4'h1) m_fl = d[4:0];
      if (a == 4'h2) m_bk = d[3:0];
   endtask
   task automatic rd(logic [3:0] a);
      exp_q.push_back(a == 4'h0 ? m_w : a == 4'h1 ? {3'h0, m_fl}
                      : a == 4'h2 ? {4'h0, m_bk} : 8'h00);
      reg_addr <= a;
      strobe(1'b0, 1'b0, 1'b1);
      @(posedge clk_sys);
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Read data stand only in the cycle after the strobe
   always @(posedge clk_sys) begin
      if (rd_d) chk(exp_q.pop_front(), reg_rdata);
      rd_d <= reg_rd && rst_n;
   end
   initial begin
      #100us;
      fail_count++;
      stop_test();
   end
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) rd(4'(i % 4));
      for (int i = 0; i < 4; i++) wr(4'(i), 8'hff);
      for (int i = 0; i < 4; i++) rd(4'(i));
      $display("test registers done");
      for (int i = 0; i < 400; i++) begin
         r = rnd();
         if (i == 200) begin
            strobe(1'b0, 1'b0, 1'b0);
            rst_n <= 1'b0;
            repeat (2) @(posedge clk_sys);
            rst_n <= 1'b1;
            m_w = 8'h00;
            m_fl = 5'h00;
            m_bk = 4'h0;
            rd(4'h0);
            $display("test mid-run reset done");
         end
         if (r[3:2] == 2'b00) wr(4'(r[1:0]), r[31:24]);
         issue(r[19:16] == 4'h0 ? 2'd2 : {1'b0, r[4]}, r[6], r[7],
               ftab[r[9:8]], r[10], btab[r[12:11]], r[15:13] == 3'h0);
         rd(4'h0);
         rd(4'h1);
         if (r[20]) rd(4'h2);
      end
      strobe(1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge clk_sys);
      $display("test random operations done");
      stop_test();
   end
endmodule
`default_nettype wire
